//--- include/sarg_pkg.sv
package sarg_pkg;

   // Region table geometry
   localparam int          SARG_NREG      = 8;          // Protection regions
   localparam int          SARG_NSUB      = 8;          // Subregions per region
   localparam int          SARG_IDX_W     = 3;          // Region index width
   localparam int          SARG_ADDR_W    = 32;         // Bus address width
   localparam int          SARG_DATA_W    = 32;         // Bus data width
   localparam int          SARG_ALIAS_BIT = 28;         // Secure alias select bit

   // Region entry field layout, packed low to high
   localparam int          SARG_F_BASE    = 0;          // Base address, 32 bits
   localparam int          SARG_F_SRD     = 32;         // Subregion disable, 8 bits
   localparam int          SARG_F_SIZE    = 40;         // Log2 of region size, 6 bits
   localparam int          SARG_F_AP      = 46;         // Access permission, 2 bits
   localparam int          SARG_F_ATTR    = 48;         // Security attribute, 2 bits
   localparam int          SARG_F_EN      = 50;         // Region enable
   localparam int          SARG_ENT_W     = 51;         // Entry width

   // Region size limits, log2 of bytes; subregions of at least 32 bytes
   localparam logic [5:0]  SARG_SIZE_MIN  = 6'h08;
   localparam logic [5:0]  SARG_SIZE_MAX  = 6'h20;
   localparam logic [5:0]  SARG_SUB_SHIFT = 6'h03;      // Log2 of subregion count

   // Access permission codes
   localparam logic [1:0]  SARG_AP_NONE   = 2'h0;       // All access disabled
   localparam logic [1:0]  SARG_AP_RO     = 2'h1;       // Read only
   localparam logic [1:0]  SARG_AP_RW     = 2'h3;       // Read and write

   // Security attribute codes from the checking logic
   localparam logic [1:0]  SARG_ATTR_NS   = 2'h0;       // Non-secure
   localparam logic [1:0]  SARG_ATTR_S    = 2'h1;       // Secure
   localparam logic [1:0]  SARG_ATTR_NSC  = 2'h2;       // Non-secure callable

   // Address space classes, decoded from address bits 31:29
   localparam logic [2:0]  SARG_TOP_CODE  = 3'h0;       // 0x0000_0000 .. 0x1FFF_FFFF
   localparam logic [2:0]  SARG_TOP_DATA  = 3'h1;       // 0x2000_0000 .. 0x3FFF_FFFF
   localparam logic [2:0]  SARG_TOP_PERI  = 3'h2;       // 0x4000_0000 .. 0x5FFF_FFFF
   localparam logic [1:0]  SARG_SP_NONE   = 2'h0;
   localparam logic [1:0]  SARG_SP_CODE   = 2'h1;
   localparam logic [1:0]  SARG_SP_DATA   = 2'h2;
   localparam logic [1:0]  SARG_SP_PERI   = 2'h3;

   // Controller states, one-hot
   typedef enum logic [3:0] {
      SARG_ST_IDLE  = 4'b0001,
      SARG_ST_CHECK = 4'b0010,
      SARG_ST_WAIT  = 4'b0100,
      SARG_ST_DONE  = 4'b1000
   } sarg_state_e;

endpackage : sarg_pkg

//--- rtl/sarg_region_mem.sv
`timescale 1ns/1ps

// Region table storage; all entries are presented through a register so
// the checker sees a stable snapshot one cycle after any write.
module sarg_region_mem
   import sarg_pkg::*;
(
   // Clock and reset
   input  wire logic                              i_clk,
   input  wire logic                              i_nrst,
   // Write port
   input  wire logic                              i_wr,
   input  wire logic [SARG_IDX_W-1:0]             i_idx,
   input  wire logic [SARG_ENT_W-1:0]             i_ent,
   // Registered read of the whole table
   output logic      [SARG_NREG*SARG_ENT_W-1:0]   o_tab
);

   // Entry storage
   logic [SARG_ENT_W-1:0] mem_q [SARG_NREG];

   // Table write; reset clears every enable so nothing matches
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < SARG_NREG; i++) begin
            mem_q[i] <= '0;
         end
      end else if (i_wr) begin
         mem_q[i_idx] <= i_ent;
      end
   end

   // Read register, flattened with entry 0 in the low bits
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tab <= '0;
      end else begin
         for (int i = 0; i < SARG_NREG; i++) begin
            o_tab[i*SARG_ENT_W +: SARG_ENT_W] <= mem_q[i];
         end
      end
   end

endmodule : sarg_region_mem

//--- rtl/sarg_guard.sv
`timescale 1ns/1ps

// Contract
// - Eight regions, each with eight subregion disable bits.
// - No match or not permitted: block, fault.
// - Regions may be read-only or no-access.
// - Address bit 28 ignored by decoding.
// - Region attribute decides secure, non-secure, callable.
// - 0x0-0x0FFF_FFFF code space, secure alias above.
// - 0x2/0x3 ranges are data space aliases.
// - 0x4/0x5 ranges are peripheral space aliases.
// - Second core reaches secure only as secure master.
// - Secure areas may be non-secure callable.
// - Address security split for primary core only.
module sarg_guard
   import sarg_pkg::*;
(
   // Clock and reset
   input  wire logic                     i_clk,
   input  wire logic                     i_nrst,
   // Region table configuration
   input  wire logic                     i_cfg_wr,
   input  wire logic [SARG_IDX_W-1:0]    i_cfg_idx,
   input  wire logic                     i_cfg_en,
   input  wire logic [1:0]               i_cfg_attr,
   input  wire logic [1:0]               i_cfg_ap,
   input  wire logic [5:0]               i_cfg_size,
   input  wire logic [SARG_NSUB-1:0]     i_cfg_srd,
   input  wire logic [SARG_ADDR_W-1:0]   i_cfg_base,
   input  wire logic                     i_second_core_secure,
   // Primary core request
   input  wire logic                     i_pc_req,
   input  wire logic [SARG_ADDR_W-1:0]   i_pc_addr,
   input  wire logic                     i_pc_wr,
   input  wire logic                     i_pc_fetch,
   input  wire logic                     i_pc_secure,
   input  wire logic [SARG_DATA_W-1:0]   i_pc_wdata,
   // Primary core response
   output logic                          o_pc_done,
   output logic                          o_pc_fault,
   output logic      [SARG_DATA_W-1:0]   o_pc_rdata,
   // Second core request
   input  wire logic                     i_sc_req,
   input  wire logic [SARG_ADDR_W-1:0]   i_sc_addr,
   input  wire logic                     i_sc_wr,
   input  wire logic [SARG_DATA_W-1:0]   i_sc_wdata,
   // Second core response
   output logic                          o_sc_done,
   output logic                          o_sc_fault,
   output logic      [SARG_DATA_W-1:0]   o_sc_rdata,
   // Bus matrix side
   output logic                          o_mtx_req,
   output logic      [SARG_ADDR_W-1:0]   o_mtx_addr,
   output logic                          o_mtx_wr,
   output logic      [SARG_DATA_W-1:0]   o_mtx_wdata,
   output logic      [1:0]               o_mtx_space,
   input  wire logic                     i_mtx_done,
   input  wire logic [SARG_DATA_W-1:0]   i_mtx_rdata
);

   // Region hit test: address and base are compared above the size boundary
   function automatic logic sarg_hit(input logic [SARG_ADDR_W-1:0] a,
                                     input logic [SARG_ADDR_W-1:0] b,
                                     input logic [5:0]             sz);
      logic [SARG_ADDR_W-1:0] msk;
      msk = {SARG_ADDR_W{1'b1}} << sz;
      return ((a & msk) == (b & msk));
   endfunction : sarg_hit

   // Clamp a programmed size into the legal range
   function automatic logic [5:0] sarg_clamp(input logic [5:0] sz);
      if (sz < SARG_SIZE_MIN) begin
         return SARG_SIZE_MIN;
      end else if (sz > SARG_SIZE_MAX) begin
         return SARG_SIZE_MAX;
      end
      return sz;
   endfunction : sarg_clamp

   // Controller state and latched request
   sarg_state_e              state_q, state_d;
   logic                     sel_sc_q;                 // Second core owns the transfer
   logic [SARG_ADDR_W-1:0]   addr_q;                   // Address as issued by the core
   logic                     wr_q;
   logic                     fetch_q;
   logic                     csec_q;                   // Primary core in secure state, cleared for the second core
   logic [SARG_DATA_W-1:0]   wdata_q;

   // Region table snapshot
   logic [SARG_NREG*SARG_ENT_W-1:0] tab;
   logic [SARG_ENT_W-1:0]           cfg_ent;

   // Pack the configuration fields into one entry
   assign cfg_ent = {i_cfg_en, i_cfg_attr, i_cfg_ap, i_cfg_size, i_cfg_srd, i_cfg_base};

   // Storage for the eight region entries
   sarg_region_mem u_mem (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_wr   (i_cfg_wr),
      .i_idx  (i_cfg_idx),
      .i_ent  (cfg_ent),
      .o_tab  (tab)
   );

   // Physical address: bit 28 is dropped before any decoding
   wire  [SARG_ADDR_W-1:0] phys_addr = {addr_q[31:29], 1'b0, addr_q[27:0]};
   wire                    alias_sec = addr_q[SARG_ALIAS_BIT];

   // Space class from the top address bits
   wire  [2:0] top = phys_addr[31:29];
   wire  [1:0] space = (top == SARG_TOP_CODE) ? SARG_SP_CODE :
                       (top == SARG_TOP_DATA) ? SARG_SP_DATA :
                       (top == SARG_TOP_PERI) ? SARG_SP_PERI :
                                                SARG_SP_NONE;

   // Per-region hit, including the subregion enable
   logic [SARG_NREG-1:0] reg_hit;
   for (genvar g = 0; g < SARG_NREG; g++) begin : g_hit
      wire [SARG_ENT_W-1:0] e   = tab[g*SARG_ENT_W +: SARG_ENT_W];
      wire [5:0]            sz  = sarg_clamp(e[SARG_F_SIZE +: 6]);
      wire [5:0]            sh  = sz - SARG_SUB_SHIFT;
      wire [SARG_ADDR_W-1:0] sa = phys_addr >> sh;
      wire [2:0]            sub = sa[2:0];
      wire [SARG_NSUB-1:0]  srd = e[SARG_F_SRD +: SARG_NSUB];
      assign reg_hit[g] = e[SARG_F_EN]
                        & sarg_hit(phys_addr, e[SARG_F_BASE +: SARG_ADDR_W], sz)
                        & ~srd[sub];
   end

   // Highest numbered hit wins, as overlapping regions are layered
   logic                  any_hit;
   logic [1:0]            hit_ap;
   logic [1:0]            hit_attr;
   always_comb begin
      any_hit  = 1'b0;
      hit_ap   = SARG_AP_NONE;
      hit_attr = SARG_ATTR_S;
      for (int i = 0; i < SARG_NREG; i++) begin
         if (reg_hit[i]) begin
            any_hit  = 1'b1;
            hit_ap   = tab[i*SARG_ENT_W + SARG_F_AP +: 2];
            hit_attr = tab[i*SARG_ENT_W + SARG_F_ATTR +: 2];
         end
      end
   end

   // Permission check: no-access blocks all, read-only blocks writes
   wire perm_ok = any_hit
                & (hit_ap != SARG_AP_NONE)
                & ~(wr_q & (hit_ap == SARG_AP_RO));

   // Primary core: the secure alias needs a secure core, the non-secure alias a non-secure attribute.
   // A non-secure entry into a callable area is legal only as a fetch.
   wire pc_sec_ok = alias_sec ? csec_q
                  : (hit_attr == SARG_ATTR_NS)
                  | ((hit_attr == SARG_ATTR_NSC) & fetch_q);

   // Second core: no alias split; secure targets need the secure master bit
   wire sc_sec_ok = (hit_attr == SARG_ATTR_NS) | i_second_core_secure;

   // Final verdict, decided apart from the decoder
   wire sec_ok = sel_sc_q ? sc_sec_ok : pc_sec_ok;
   wire allow  = (space != SARG_SP_NONE) & perm_ok & sec_ok;

   // Arbitration: primary core first; a held second core request waits
   wire take_pc = i_pc_req;
   wire take_sc = i_sc_req & ~i_pc_req;

   // Next-state decode
   always_comb begin
      state_d = state_q;
      case (state_q)
         SARG_ST_IDLE: begin
            if (take_pc | take_sc) begin
               state_d = SARG_ST_CHECK;
            end
         end
         SARG_ST_CHECK: begin
            // Blocked access skips the matrix entirely
            state_d = allow ? SARG_ST_WAIT : SARG_ST_DONE;
         end
         SARG_ST_WAIT: begin
            if (i_mtx_done) begin
               state_d = SARG_ST_DONE;
            end
         end
         SARG_ST_DONE: begin
            state_d = SARG_ST_IDLE;
         end
         default: begin
            state_d = SARG_ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= SARG_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Request latch, captured only when idle
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sel_sc_q <= 1'b0;
         addr_q   <= '0;
         wr_q     <= 1'b0;
         fetch_q  <= 1'b0;
         csec_q   <= 1'b0;
         wdata_q  <= '0;
      end else if ((state_q == SARG_ST_IDLE) & (take_pc | take_sc)) begin
         sel_sc_q <= take_sc;
         addr_q   <= take_pc ? i_pc_addr  : i_sc_addr;
         wr_q     <= take_pc ? i_pc_wr    : i_sc_wr;
         fetch_q  <= take_pc & i_pc_fetch;
         csec_q   <= take_pc & i_pc_secure;
         wdata_q  <= take_pc ? i_pc_wdata : i_sc_wdata;
      end
   end

   // Matrix request: a single pulse, only for allowed accesses
   wire issue = (state_q == SARG_ST_CHECK) & allow;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_mtx_req   <= 1'b0;
         o_mtx_addr  <= '0;
         o_mtx_wr    <= 1'b0;
         o_mtx_wdata <= '0;
         o_mtx_space <= SARG_SP_NONE;
      end else begin
         o_mtx_req <= issue;
         if (issue) begin
            o_mtx_addr  <= phys_addr;
            o_mtx_wr    <= wr_q;
            o_mtx_wdata <= wdata_q;
            o_mtx_space <= space;
         end
      end
   end

   // Response timing: the fault shows where the matrix request would have shown
   wire blk  = (state_q == SARG_ST_CHECK) & ~allow;
   wire cmpl = (state_q == SARG_ST_WAIT) & i_mtx_done;
   wire fin  = blk | cmpl;
   // Blocked or write responses carry no data
   wire [SARG_DATA_W-1:0] rsp_data = (cmpl & ~wr_q) ? i_mtx_rdata : '0;

   // Core response registers, one-cycle done pulses
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pc_done  <= 1'b0;
         o_pc_fault <= 1'b0;
         o_pc_rdata <= '0;
         o_sc_done  <= 1'b0;
         o_sc_fault <= 1'b0;
         o_sc_rdata <= '0;
      end else begin
         o_pc_done  <= fin & ~sel_sc_q;
         o_pc_fault <= blk & ~sel_sc_q;
         o_sc_done  <= fin & sel_sc_q;
         o_sc_fault <= blk & sel_sc_q;
         if (fin & ~sel_sc_q) begin
            o_pc_rdata <= rsp_data;
         end
         if (fin & sel_sc_q) begin
            o_sc_rdata <= rsp_data;
         end
      end
   end

endmodule : sarg_guard

//--- tb/sarg_guard_assertions.sv
`timescale 1ns/1ps

// Checks on the guard's response and matrix sides, from the top ports only
module sarg_guard_checker
   import sarg_pkg::*;
(
   // Clock and reset
   input  wire logic                     i_clk,
   input  wire logic                     i_nrst,
   // Core responses
   input  wire logic                     o_pc_done,
   input  wire logic                     o_pc_fault,
   input  wire logic [SARG_DATA_W-1:0]   o_pc_rdata,
   input  wire logic                     o_sc_done,
   input  wire logic                     o_sc_fault,
   // Matrix side
   input  wire logic                     o_mtx_req,
   input  wire logic [SARG_ADDR_W-1:0]   o_mtx_addr,
   input  wire logic [1:0]               o_mtx_space,
   input  wire logic                     i_mtx_done
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // Class the forwarded address should carry
   wire logic [2:0] top_w = o_mtx_addr[31:29];
   wire logic [1:0] exp_space_w = (top_w == SARG_TOP_CODE) ? SARG_SP_CODE :
                                  (top_w == SARG_TOP_DATA) ? SARG_SP_DATA : SARG_SP_PERI;

   // No fault may follow a forwarded request in the two cycles after it
   sequence s_quiet2;
      (!o_pc_fault && !o_sc_fault) [*2];
   endsequence
   // One clean completion, to exactly one core, after the matrix answers
   sequence s_reply;
      ##1 ((o_pc_done ^ o_sc_done) && !o_pc_fault && !o_sc_fault);
   endsequence

   a_pc_fault_done: assert property (
      o_pc_fault |-> o_pc_done) else $error("primary fault without done");
   a_sc_fault_done: assert property (
      o_sc_fault |-> o_sc_done) else $error("second core fault without done");
   a_fault_no_data: assert property (
      o_pc_fault |-> o_pc_rdata == '0) else $error("faulted read returned data");
   a_alias_bit_clr: assert property (
      o_mtx_req |-> !o_mtx_addr[SARG_ALIAS_BIT]) else $error("alias bit forwarded");
   a_mtx_space_map: assert property (
      o_mtx_req |-> top_w <= SARG_TOP_PERI && o_mtx_space == exp_space_w)
      else $error("wrong space class");
   a_done_one_cyc: assert property (
      o_pc_done |=> !o_pc_done) else $error("done longer than one cycle");
   a_mtx_req_pulse: assert property (
      o_mtx_req |=> !o_mtx_req) else $error("matrix request longer than a pulse");
   a_fwd_no_fault: assert property (
      o_mtx_req |=> s_quiet2) else $error("fault after forwarded request");
   a_mtx_reply: assert property (
      i_mtx_done |-> s_reply) else $error("matrix reply not completed");

endmodule : sarg_guard_checker

bind sarg_guard sarg_guard_checker i_chk (.i_clk, .i_nrst, .o_pc_done, .o_pc_fault,
   .o_pc_rdata, .o_sc_done, .o_sc_fault, .o_mtx_req, .o_mtx_addr, .o_mtx_space, .i_mtx_done);

//--- tb/sarg_mtx_model.sv
`timescale 1ns/1ps

// Behavioural bus matrix: answers each request after one or five cycles
module sarg_mtx_model (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_nrst,
   // Request from the guard
   input  wire logic          i_req,
   input  wire logic [31:0]   i_addr,
   input  wire logic [1:0]    i_space,
   input  wire logic          i_slow,
   // Reply and capture
   output logic               o_done,
   output logic [31:0]        o_rdata,
   output logic [31:0]        o_last_addr,
   output logic [1:0]         o_last_space,
   output logic [15:0]        o_n_req
);
   logic       busy;                          // A request is pending
   logic [2:0] cnt;                           // Cycles left before reply

   // Read data is inverted address; between replies it churns so stale data shows
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {o_done, o_rdata, o_last_addr, o_last_space, o_n_req, busy, cnt} <= '0;
      end else begin
         o_done <= 1'b0;
         o_rdata <= o_rdata + 32'h1357_9BDF;
         if (i_req) begin
            busy <= 1'b1;
            cnt <= i_slow ? 3'h4 : 3'h0;
            o_last_addr <= i_addr;
            o_last_space <= i_space;
            o_n_req <= o_n_req + 16'h0001;
         end else if (busy && cnt == 3'h0) begin
            busy <= 1'b0;
            o_done <= 1'b1;
            o_rdata <= ~o_last_addr;
         end else if (busy) begin
            cnt <= cnt - 3'h1;
         end
      end
   end

endmodule : sarg_mtx_model

//--- tb/tb.sv
`timescale 1ns/1ps

module tb;
   import sarg_pkg::*;
   logic i_clk = 0, i_nrst = 0, i_cfg_wr = 0, i_cfg_en = 0, i_scs = 0, slow = 0;
   logic [2:0] i_cfg_idx = 0;
   logic [1:0] i_cfg_attr = 0, i_cfg_ap = 0, m_space, o_mtx_space;
   logic [5:0] i_cfg_size = 0;
   logic [7:0] i_cfg_srd = 0;
   logic [31:0] i_cfg_base = 0, i_pc_addr = 0, i_sc_addr = 0, m_addr, o_mtx_addr, i_mtx_rdata;
   logic i_pc_req = 0, i_pc_wr = 0, i_pc_fetch = 0, i_pc_secure = 0, i_sc_req = 0, i_sc_wr = 0;
   logic o_pc_done, o_pc_fault, o_sc_done, o_sc_fault, o_mtx_req, o_mtx_wr, i_mtx_done;
   logic [31:0] o_pc_rdata, o_sc_rdata, o_mtx_wdata;
   logic [15:0] n_mreq;
   int err_total = 0, checks = 0;

   // Clock at 40 MHz
   always #12.5 i_clk = ~i_clk;

   sarg_guard i_dut (.i_clk, .i_nrst, .i_cfg_wr, .i_cfg_idx, .i_cfg_en, .i_cfg_attr,
      .i_cfg_ap, .i_cfg_size, .i_cfg_srd, .i_cfg_base, .i_second_core_secure(i_scs),
      .i_pc_req, .i_pc_addr, .i_pc_wr, .i_pc_fetch, .i_pc_secure, .i_pc_wdata(~i_pc_addr),
      .o_pc_done, .o_pc_fault, .o_pc_rdata, .i_sc_req, .i_sc_addr, .i_sc_wr,
      .i_sc_wdata(i_sc_addr), .o_sc_done, .o_sc_fault, .o_sc_rdata, .o_mtx_req,
      .o_mtx_addr, .o_mtx_wr, .o_mtx_wdata, .o_mtx_space, .i_mtx_done, .i_mtx_rdata);
   sarg_mtx_model i_mtx (.i_clk, .i_nrst, .i_req(o_mtx_req), .i_addr(o_mtx_addr),
      .i_space(o_mtx_space), .i_slow(slow), .o_done(i_mtx_done), .o_rdata(i_mtx_rdata),
      .o_last_addr(m_addr), .o_last_space(m_space), .o_n_req(n_mreq));

   task automatic print_verdict;
      if (err_total == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         err_total++;
      end
   endtask : chk

   // One region write, then two cycles for the snapshot to reach the checker
   task automatic cfg(input logic [2:0] ix, input logic [1:0] at, ap, input logic [5:0] sz,
                      input logic [7:0] srd, input logic [31:0] b, input logic en = 1'b1);
      @(negedge i_clk);
      {i_cfg_wr, i_cfg_idx, i_cfg_en, i_cfg_attr, i_cfg_ap, i_cfg_size, i_cfg_srd,
       i_cfg_base} = {1'b1, ix, en, at, ap, sz, srd, b};
      @(negedge i_clk);
      i_cfg_wr = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask : cfg

   // One access held until done, then judged on fault, data and matrix traffic
   task automatic acc(input logic sc, input logic [31:0] a, input logic wr, fe, sec, flt);
      logic [15:0] k0;
      logic d;
      int n;
      k0 = n_mreq;
      @(negedge i_clk);
      if (sc) {i_sc_req, i_sc_addr, i_sc_wr} = {1'b1, a, wr};
      else {i_pc_req, i_pc_addr, i_pc_wr, i_pc_fetch, i_pc_secure} = {1'b1, a, wr, fe, sec};
      n = 0;
      d = 1'b0;
      while (d !== 1'b1 && n < 40) begin
         @(negedge i_clk);
         n++;
         d = sc ? o_sc_done : o_pc_done;
      end
      {i_pc_req, i_sc_req} = 2'b00;
      if (n >= 40) begin
         $display("wrong value done expected 1 seen %b", d);
         err_total++;
         print_verdict();
      end
      chk("fault", {31'h0, flt}, {31'h0, sc ? o_sc_fault : o_pc_fault});
      chk("rdata", (flt | wr) ? 32'h0 : ~(a & 32'hEFFF_FFFF), sc ? o_sc_rdata : o_pc_rdata);
      chk("matrix count", {16'h0, flt ? k0 : k0 + 16'h1}, {16'h0, n_mreq});
      if (!flt) chk("matrix addr", a & 32'hEFFF_FFFF, m_addr);
      if (!flt) chk("space", {30'h0, a[30:29] + 2'h1}, {30'h0, m_space});
      // Forwarded write flag and data must be those the core issued
      if (!flt) chk("matrix wr", {31'h0, wr}, {31'h0, o_mtx_wr});
      if (!flt) chk("matrix wdata", sc ? a : ~a, o_mtx_wdata);
   endtask : acc

   // Both aliases of code, data and peripheral space reach one location
   task automatic t_alias;
      logic [31:0] b [3] = '{32'h0000_0100, 32'h2000_0200, 32'h4000_0300};
      cfg(3'h0, SARG_ATTR_NS, SARG_AP_RW, 6'h20, 8'h00, 32'h0);
      foreach (b[i]) begin
         slow = i[0];
         acc(0, b[i], 0, 0, 0, 0);
         acc(0, b[i] | 32'h1000_0000, 0, 0, 1, 0);
         acc(0, b[i], 1, 0, 0, 0);
      end
      acc(0, 32'h6000_0000, 0, 0, 1, 1);
      acc(1, 32'h3000_0200, 0, 0, 0, 0);
   endtask : t_alias

   // Read-only and no-access regions, then an address no region covers
   task automatic t_perm;
      cfg(3'h1, SARG_ATTR_NS, SARG_AP_RO, 6'h10, 8'h00, 32'h2000_0000);
      acc(0, 32'h2000_0010, 0, 0, 0, 0);
      acc(0, 32'h2000_0010, 1, 0, 0, 1);
      cfg(3'h1, SARG_ATTR_NS, SARG_AP_NONE, 6'h10, 8'h00, 32'h2000_0000);
      acc(0, 32'h2000_0010, 0, 0, 0, 1);
      cfg(3'h0, SARG_ATTR_NS, SARG_AP_RW, 6'h20, 8'h00, 32'h0, 1'b0);
      acc(0, 32'h2002_0000, 0, 0, 0, 1);
   endtask : t_perm

   // Disabled subregion in the top region, then attribute-based access
   task automatic t_sub_sec;
      cfg(3'h7, SARG_ATTR_NS, SARG_AP_RW, 6'h10, 8'h04, 32'h2001_0000);
      acc(0, 32'h2001_4000, 0, 0, 0, 1);
      acc(0, 32'h2001_6000, 0, 0, 0, 0);
      cfg(3'h3, SARG_ATTR_S, SARG_AP_RW, 6'h10, 8'h00, 32'h4000_0000);
      acc(0, 32'h4000_0010, 0, 0, 0, 1);
      acc(0, 32'h5000_0010, 0, 0, 1, 0);
      acc(0, 32'h5000_0010, 0, 0, 0, 1);
      acc(1, 32'h4000_0010, 0, 0, 0, 1);
      i_scs = 1'b1;
      acc(1, 32'h4000_0010, 0, 0, 0, 0);
      acc(1, 32'h4000_0010, 1, 0, 0, 0);
      cfg(3'h4, SARG_ATTR_NSC, SARG_AP_RW, 6'h10, 8'h00, 32'h0);
      acc(0, 32'h0000_0040, 0, 1, 0, 0);
      acc(0, 32'h0000_0040, 0, 0, 0, 1);
   endtask : t_sub_sec

   // Reset, then an empty table faults everything before the scenarios run
   initial begin
      repeat (12) @(negedge i_clk);
      i_nrst = 1'b1;
      acc(0, 32'h2000_0000, 0, 0, 0, 1);
      t_alias();
      t_perm();
      t_sub_sec();
      print_verdict();
   end

endmodule : tb
